// file: rtl/atp_pkg.sv
package atp_pkg;

	// ******************************************************************
	// register map
	// ******************************************************************
	localparam logic [7:0] ADDR_USER_PATTERN1_LOW  = 8'h19;
	localparam logic [7:0] ADDR_USER_PATTERN1_HIGH = 8'h1A;
	localparam logic [7:0] ADDR_USER_PATTERN2_LOW  = 8'h1B;
	localparam logic [7:0] ADDR_USER_PATTERN2_HIGH = 8'h1C;
	localparam logic [7:0] ADDR_LOWPASS_TUNE       = 8'h2B;
	localparam logic [7:0] ADDR_SAT_INPUT_CFG      = 8'h2C;

	localparam logic [7:0] RST_USER_PATTERN = 8'h00;
	localparam logic [7:0] RST_LOWPASS_TUNE = 8'h00;
	localparam logic [7:0] RST_SAT_INPUT    = 8'h61;

	// ******************************************************************
	// field positions
	// ******************************************************************
	localparam int TUNE_BIT     = 6;
	localparam int SAT_LIM_LSB  = 5;
	localparam int SAT_HYST_BIT = 4;
	localparam int IMP_BIT      = 0;
	localparam logic [7:0] TUNE_MASK = 8'h40;
	localparam logic [7:0] CFG_MASK  = 8'hF1;

	// ******************************************************************
	// test modes and fixed words
	// ******************************************************************
	typedef enum logic [3:0] {
		TM_OFF = 4'h0, TM_MID = 4'h1, TM_PFS = 4'h2, TM_NFS = 4'h3,
		TM_CHECKER = 4'h4, TM_PN_LONG = 4'h5, TM_PN_SHORT = 4'h6,
		TM_WORD_TOGGLE = 4'h7, TM_USER = 4'h8, TM_BIT_TOGGLE = 4'h9,
		TM_SYNC = 4'hA, TM_ONE_BIT = 4'hB, TM_MIXED = 4'hC
	} atp_mode_t;

	localparam logic [11:0] W_MID     = 12'h800;
	localparam logic [11:0] W_ONES    = 12'hFFF;
	localparam logic [11:0] W_ZEROS   = 12'h000;
	localparam logic [11:0] W_CHECK_A = 12'hAAA;
	localparam logic [11:0] W_CHECK_B = 12'h555;
	localparam logic [11:0] W_SYNC    = 12'h03F;
	localparam logic [11:0] W_MIXED   = 12'hA33;

	localparam logic [22:0] PN_LONG_SEED  = 23'h7FFFFF;
	localparam logic [8:0]  PN_SHORT_SEED = 9'h1FF;

	// ******************************************************************
	// carriers
	// ******************************************************************
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} atp_reg_req_t;

	typedef struct packed {
		logic [2:0] sat_limit;
		logic       sat_hyst_high;
		logic       imp_high;
	} atp_analog_cfg_t;

endpackage

// file: rtl/atp_top.sv
// Function
// - four-bit code selects pattern; zero is off
// - shorts give constant words, formatted
// - checkerboard and word toggle, unformatted
// - user mode word one from pattern one
// - user mode word two from pattern two
// - four single fixed words, unformatted
// - tune bit set by write, self-clears
// - saturation threshold field, default code 011
// - hysteresis bit selects low or high
// - impedance bit, default high, global
// - pattern one high byte, resets zero
module atp_top
	import atp_pkg::*;
(
	input  wire logic        CORE_CLK,
	input  wire logic        RESETN,
	input  atp_reg_req_t     REG_REQ,
	output logic [7:0]       REG_RDATA,
	input  wire logic [3:0]  TEST_MODE,
	input  wire logic        TWOS_COMP,
	input  wire logic [11:0] ADC_DATA,
	input  wire logic        TUNE_DONE,
	output logic             TUNE_START,
	output atp_analog_cfg_t  ANALOG_CFG,
	output logic [11:0]      DATA_OUT
);

	// ******************************************************************
	// register state
	// ******************************************************************
	// user pattern bytes; only the low nibble of each high byte reaches the output
	logic [7:0]  up1_lo_q;
	logic [7:0]  up1_lo_d;
	logic [7:0]  up1_hi_q;
	logic [7:0]  up1_hi_d;
	logic [7:0]  up2_lo_q;
	logic [7:0]  up2_lo_d;
	logic [7:0]  up2_hi_q;
	logic [7:0]  up2_hi_d;
	// tune trigger and global analog controls
	logic [7:0]  tune_q;
	logic [7:0]  tune_d;
	logic [7:0]  cfg_q;
	logic [7:0]  cfg_d;
	logic        tune_start_q;
	logic        tune_start_d;
	// read-back holds its last value between reads
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;

	// writes land byte-wise; undefined bits of 0x2B/0x2C stay as reset
	always_comb begin
		// defaults hold every register except the tune start pulse, which defaults to zero
		up1_lo_d     = up1_lo_q;
		up1_hi_d     = up1_hi_q;
		up2_lo_d     = up2_lo_q;
		up2_hi_d     = up2_hi_q;
		tune_d       = tune_q;
		cfg_d        = cfg_q;
		tune_start_d = 1'b0;
		// finish clears first so a fresh write in the same cycle wins
		if (TUNE_DONE) begin
			tune_d[TUNE_BIT] = 1'b0;
		end
		if (REG_REQ.wr) begin
			case (REG_REQ.addr)
				ADDR_USER_PATTERN1_LOW:  up1_lo_d = REG_REQ.wdata;
				ADDR_USER_PATTERN1_HIGH: up1_hi_d = REG_REQ.wdata;
				ADDR_USER_PATTERN2_LOW:  up2_lo_d = REG_REQ.wdata;
				ADDR_USER_PATTERN2_HIGH: up2_hi_d = REG_REQ.wdata;
				ADDR_LOWPASS_TUNE: begin
					if (REG_REQ.wdata[TUNE_BIT]) begin
						tune_d[TUNE_BIT] = 1'b1;
						tune_start_d     = 1'b1;
					end
				end
				ADDR_SAT_INPUT_CFG: begin
					// reserved threshold codes are stored as written; software avoids them
					// bits 3:1 have no function and always read back as zero
					cfg_d = (REG_REQ.wdata & CFG_MASK) | (RST_SAT_INPUT & ~CFG_MASK);
				end
				default: ;
			endcase
		end
	end

	// read mux; unmapped offsets read zero so a stray read leaks no state
	always_comb begin
		rdata_d = rdata_q;
		if (REG_REQ.rd) begin
			case (REG_REQ.addr)
				ADDR_USER_PATTERN1_LOW:  rdata_d = up1_lo_q;
				ADDR_USER_PATTERN1_HIGH: rdata_d = up1_hi_q;
				ADDR_USER_PATTERN2_LOW:  rdata_d = up2_lo_q;
				ADDR_USER_PATTERN2_HIGH: rdata_d = up2_hi_q;
				ADDR_LOWPASS_TUNE:       rdata_d = tune_q & TUNE_MASK;
				ADDR_SAT_INPUT_CFG:      rdata_d = cfg_q;
				default:                 rdata_d = 8'h00;
			endcase
		end
	end

	// register bank
	// reset loads constants only, so the release edge never sees stale data
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			up1_lo_q     <= RST_USER_PATTERN;
			up1_hi_q     <= RST_USER_PATTERN;
			up2_lo_q     <= RST_USER_PATTERN;
			up2_hi_q     <= RST_USER_PATTERN;
			tune_q       <= RST_LOWPASS_TUNE;
			cfg_q        <= RST_SAT_INPUT;
			rdata_q      <= 8'h00;
			tune_start_q <= 1'b0;
		end else begin
			up1_lo_q     <= up1_lo_d;
			up1_hi_q     <= up1_hi_d;
			up2_lo_q     <= up2_lo_d;
			up2_hi_q     <= up2_hi_d;
			tune_q       <= tune_d;
			cfg_q        <= cfg_d;
			rdata_q      <= rdata_d;
			tune_start_q <= tune_start_d;
		end
	end

	// bus outputs come straight from flops
	assign REG_RDATA  = rdata_q;
	assign TUNE_START = tune_start_q;

	// ******************************************************************
	// analog controls
	// ******************************************************************
	// one setting serves every channel; nothing here is per channel
	assign ANALOG_CFG = '{sat_limit:     cfg_q[SAT_LIM_LSB +: 3],
	                      sat_hyst_high: cfg_q[SAT_HYST_BIT],
	                      imp_high:      cfg_q[IMP_BIT]};

	// ******************************************************************
	// pattern generator
	// ******************************************************************
	logic [3:0]  mode_q;
	logic [3:0]  mode_d;
	logic        phase_q;
	logic        phase_d;
	logic [22:0] pnl_q;
	logic [22:0] pnl_d;
	logic [8:0]  pns_q;
	logic [8:0]  pns_d;
	logic [11:0] word_d;
	logic [11:0] out_q;
	logic        fmt;
	logic        mode_new;

	// mode_q holds last cycle's code; a difference marks a fresh selection
	assign mode_new = (TEST_MODE != mode_q);

	// phase and LFSRs restart on a mode change so the first word is always word one;
	// a one-cycle glitch on the mode code therefore restarts any sequence
	always_comb begin
		mode_d  = TEST_MODE;
		// phase 0 carries word one, phase 1 word two
		phase_d = mode_new ? 1'b0 : ~phase_q;
		// long sequence: 23-bit register with taps at bits 22 and 17
		pnl_d   = (mode_new || TEST_MODE != TM_PN_LONG) ? PN_LONG_SEED
		          : {pnl_q[21:0], pnl_q[22] ^ pnl_q[17]};
		// short sequence: 9-bit register with taps at bits 8 and 4
		pns_d   = (mode_new || TEST_MODE != TM_PN_SHORT) ? PN_SHORT_SEED
		          : {pns_q[7:0], pns_q[8] ^ pns_q[4]};
		fmt     = 1'b0;
		// phase 0 after a change means word one goes out first
		// codes D to F are not patterns and pass live samples
		case (TEST_MODE)
			TM_OFF:         word_d = ADC_DATA;
			TM_MID:         begin word_d = W_MID;   fmt = 1'b1; end
			TM_PFS:         begin word_d = W_ONES;  fmt = 1'b1; end
			TM_NFS:         begin word_d = W_ZEROS; fmt = 1'b1; end
			TM_CHECKER:     word_d = phase_d ? W_CHECK_B : W_CHECK_A;
			TM_PN_LONG:     begin word_d = pnl_d[22:11]; fmt = 1'b1; end
			TM_PN_SHORT:    begin word_d = {pns_d, pns_d[8:6]}; fmt = 1'b1; end
			TM_WORD_TOGGLE: word_d = phase_d ? W_ZEROS : W_ONES;
			TM_USER:        word_d = phase_d ? {up2_hi_q[3:0], up2_lo_q}
			                                 : {up1_hi_q[3:0], up1_lo_q};
			TM_BIT_TOGGLE:  word_d = W_CHECK_A;
			TM_SYNC:        word_d = W_SYNC;
			TM_ONE_BIT:     word_d = W_MID;
			TM_MIXED:       word_d = W_MIXED;
			default:        word_d = ADC_DATA;
		endcase
		// format select flips the MSB (offset binary to twos complement)
		// checkerboard, toggles and user words bypass it, as their words are fixed
		if (fmt && TWOS_COMP) begin
			word_d = word_d ^ W_MID;
		end
	end

	// output register; every word leaves one edge after its mode is seen
	// sequence registers reset to their seeds, so no sequence starts from zero
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			mode_q  <= TM_OFF;
			phase_q <= 1'b1;
			pnl_q   <= PN_LONG_SEED;
			pns_q   <= PN_SHORT_SEED;
			out_q   <= 12'h000;
		end else begin
			mode_q  <= mode_d;
			phase_q <= phase_d;
			pnl_q   <= pnl_d;
			pns_q   <= pns_d;
			out_q   <= word_d;
		end
	end

	// ******************************************************************
	// output word
	// ******************************************************************
	// data leaves straight from the flop, so the capture side sees clean words
	assign DATA_OUT = out_q;

endmodule

// file: test/atp_checker.sv
// ********************************
// pattern and register checker
// ********************************
module atp_checker
	import atp_pkg::*;
(
	input wire logic        CORE_CLK,
	input wire logic        RESETN,
	input atp_reg_req_t     REG_REQ,
	input wire logic [3:0]  TEST_MODE,
	input wire logic        TWOS_COMP,
	input wire logic        TUNE_START,
	input atp_analog_cfg_t  ANALOG_CFG,
	input wire logic [11:0] DATA_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       tune_wr;
	logic [4:0] cfg_new;
	// decoded writes, so that $past only ever sees a plain signal
	assign tune_wr = REG_REQ.wr && REG_REQ.addr == 8'h2B && REG_REQ.wdata[6];
	assign cfg_new = {REG_REQ.wdata[7:4], REG_REQ.wdata[0]};
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	// each output word follows the mode sampled one edge earlier
	property p_mid; TEST_MODE==4'h1 |=> DATA_OUT=={~$past(TWOS_COMP), 11'h000}; endproperty
	a_mid: assert property (p_mid) else $error("midscale word wrong");
	property p_alt; TEST_MODE==4'h4 ##1 TEST_MODE==4'h4 |=> DATA_OUT==~$past(DATA_OUT); endproperty
	a_alt: assert property (p_alt) else $error("checkerboard not alternating");
	property p_first; $changed(TEST_MODE) && TEST_MODE==4'h7 |=> DATA_OUT==12'hFFF; endproperty
	a_first: assert property (p_first) else $error("toggle first word wrong");
	property p_sync; TEST_MODE==4'hA |=> DATA_OUT==12'h03F; endproperty
	a_sync: assert property (p_sync) else $error("sync word wrong");
	property p_mix; TEST_MODE==4'hC |=> DATA_OUT==12'hA33; endproperty
	a_mix: assert property (p_mix) else $error("mixed word wrong");
	// tune start is one pulse, and only after a write of the tune bit
	property p_tune; tune_wr |=> TUNE_START; endproperty
	a_tune: assert property (p_tune) else $error("tune start missing");
	property p_src; TUNE_START |-> $past(tune_wr); endproperty
	a_src: assert property (p_src) else $error("tune start without write");
	property p_cfg; REG_REQ.wr && REG_REQ.addr==8'h2C |=> ANALOG_CFG==$past(cfg_new); endproperty
	a_cfg: assert property (p_cfg) else $error("analog config not updated");
endmodule
bind atp_top atp_checker chk_u (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .REG_REQ(REG_REQ),
	.TEST_MODE(TEST_MODE), .TWOS_COMP(TWOS_COMP), .TUNE_START(TUNE_START),
	.ANALOG_CFG(ANALOG_CFG), .DATA_OUT(DATA_OUT));

// file: test/atp_capture.sv
// ********************************
// downstream word capture
// ********************************
module atp_capture (
	input wire logic        clk,
	input wire logic [11:0] word_in,
	output logic [11:0]     word_q
);
	timeunit 1ns;
	timeprecision 1ns;
	// takes every word; it never stalls, as the output has no handshake
	always_ff @(posedge clk) begin
		word_q <= word_in;
	end
endmodule

// file: test/test_adc_output_test_patterns.sv
// ********************************
// pattern generator testbench
// ********************************
module test_adc_output_test_patterns
	import atp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic            clk = 1'b0;
	logic            rst_n = 1'b0;
	atp_reg_req_t    req = '0;
	logic [7:0]      rdata;
	logic [3:0]      mode = 4'h0;
	logic            tw = 1'b0;
	logic [11:0]     adc = 12'h5A5;
	logic            done = 1'b0;
	logic            tstart;
	atp_analog_cfg_t cfg;
	logic [11:0]     dout;
	logic [11:0]     cap;
	logic [11:0]     pn [16];
	int              errors = 0;
	int              checks = 0;
	always #25 clk = ~clk;
	atp_top dut_u (.CORE_CLK(clk), .RESETN(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
		.TEST_MODE(mode), .TWOS_COMP(tw), .ADC_DATA(adc), .TUNE_DONE(done),
		.TUNE_START(tstart), .ANALOG_CFG(cfg), .DATA_OUT(dout));
	atp_capture cap_u (.clk(clk), .word_in(dout), .word_q(cap));
	task automatic cmp(input string n, input logic [11:0] e, input logic [11:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// a request stands one cycle and is taken at the following edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{1'b1, 1'b0, a, d};
		@(posedge clk) req <= '0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk) req <= '0;
		#1 cmp("rdata", {4'h0, e}, {4'h0, rdata});
	endtask
	// word one lands after the edge that first sees the mode
	task automatic seq(input logic [3:0] m, input logic [11:0] a, b, input logic f);
		logic [11:0] x;
		@(posedge clk) mode <= m;
		x = (f && tw) ? 12'h800 : 12'h000;
		for (int k = 0; k < 3; k++) begin
			@(posedge clk) #1 cmp("dout", (k == 1 ? b : a) ^ x, dout);
			if (k > 0) begin
				cmp("capture", (k == 2 ? b : a) ^ x, cap);
			end
		end
	endtask
	task automatic t_regs;
		rd(ADDR_USER_PATTERN2_LOW, 8'h00);
		rd(ADDR_USER_PATTERN2_HIGH, 8'h00);
		rd(ADDR_USER_PATTERN1_HIGH, 8'h00);
		rd(ADDR_SAT_INPUT_CFG, 8'h61);
		cmp("cfg", 12'h00D, {7'h00, cfg});
		rd(8'h30, 8'h00);
		wr(ADDR_SAT_INPUT_CFG, 8'hF0);
		cmp("cfg", 12'h01E, {7'h00, cfg});
		rd(ADDR_SAT_INPUT_CFG, 8'hF0);
		wr(ADDR_LOWPASS_TUNE, 8'h40);
		cmp("start", 12'h001, {11'h000, tstart});
		rd(ADDR_LOWPASS_TUNE, 8'h40);
		@(posedge clk) done <= 1'b1;
		@(posedge clk) done <= 1'b0;
		rd(ADDR_LOWPASS_TUNE, 8'h00);
		// a write that meets the finish in one cycle still sets the bit
		@(posedge clk) begin
			req  <= '{1'b1, 1'b0, ADDR_LOWPASS_TUNE, 8'h40};
			done <= 1'b1;
		end
		@(posedge clk) begin
			req  <= '0;
			done <= 1'b0;
		end
		#1 cmp("start", 12'h001, {11'h000, tstart});
		rd(ADDR_LOWPASS_TUNE, 8'h40);
		$display("register test done");
	endtask
	// both data formats; only shorts and pn words take the format
	task automatic t_modes;
		wr(ADDR_USER_PATTERN1_LOW, 8'h34);
		wr(ADDR_USER_PATTERN1_HIGH, 8'h12);
		wr(ADDR_USER_PATTERN2_LOW, 8'hCD);
		wr(ADDR_USER_PATTERN2_HIGH, 8'hAB);
		rd(ADDR_USER_PATTERN1_LOW, 8'h34);
		rd(ADDR_USER_PATTERN1_HIGH, 8'h12);
		rd(ADDR_USER_PATTERN2_HIGH, 8'hAB);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) tw <= i[0];
			adc <= i[0] ? 12'h3C6 : 12'h5A5;
			seq(4'h0, i[0] ? 12'h3C6 : 12'h5A5, i[0] ? 12'h3C6 : 12'h5A5, 1'b0);
			seq(4'h1, 12'h800, 12'h800, 1'b1);
			seq(4'h2, 12'hFFF, 12'hFFF, 1'b1);
			seq(4'h3, 12'h000, 12'h000, 1'b1);
			seq(4'h4, 12'hAAA, 12'h555, 1'b0);
			seq(4'h7, 12'hFFF, 12'h000, 1'b0);
			seq(4'h8, 12'h234, 12'hBCD, 1'b0);
			seq(4'h9, 12'hAAA, 12'hAAA, 1'b0);
			seq(4'hA, 12'h03F, 12'h03F, 1'b0);
			seq(4'hB, 12'h800, 12'h800, 1'b0);
			seq(4'hC, 12'hA33, 12'hA33, 1'b0);
			seq(4'hF, adc, adc, 1'b0);
		end
		$display("pattern test done");
	endtask
	// pn words follow the fixed polynomials from the seed; a reselect replays them
	task automatic t_pn;
		logic [22:0] rl;
		logic [8:0]  rs;
		logic [11:0] e;
		for (int m = 5; m < 7; m++) begin
			rl = PN_LONG_SEED;
			rs = PN_SHORT_SEED;
			@(posedge clk) mode <= m[3:0];
			for (int k = 0; k < 16; k++) begin
				e = (m == 5) ? rl[22:11] : {rs, rs[8:6]};
				rl = {rl[21:0], rl[22] ^ rl[17]};
				rs = {rs[7:0], rs[8] ^ rs[4]};
				@(posedge clk) #1 pn[k] = dout;
				cmp("pn seq", e ^ {tw, 11'h000}, dout);
			end
			@(posedge clk) mode <= 4'h0;
			@(posedge clk) mode <= m[3:0];
			for (int k = 0; k < 16; k++) begin
				@(posedge clk) #1 cmp("pn", pn[k], dout);
			end
		end
		$display("pn test done");
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_modes;
		t_pn;
		stop_test;
	end
	// the run needs some 210 cycles; this cuts a hang short
	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		stop_test;
	end
endmodule
